// ==== common/pia_pkg.sv ====
// ==========================================================================
// shared constants of the peripheral interrupt aggregation block
// ==========================================================================
package pia_pkg;

	// ======================================================================
	// sizes
	localparam int NUM_LINES        = 23;  // numbered lines towards the core
	localparam int LINE_W           = 5;   // width of a line number
	localparam int SRC_W            = 8;   // flag bits per peripheral
	localparam int NUM_SYS          = 7;   // system peripherals
	localparam int NUM_SERIAL       = 6;   // serial units
	localparam int NUM_TIMER        = 8;   // timer units
	localparam int NUM_PRIO_REGS    = 8;   // priority register bank
	localparam int PRIO_IDX_W       = 3;
	localparam int PRIO_REG_W       = 32;
	localparam int PRIO_W           = 2;   // implemented priority bits
	localparam int LINES_PER_PRIO   = 4;   // one byte field per line
	localparam int PRIO_FIELD_BITS  = 8;
	localparam int PRIO_FIELD_TOP   = 7;   // priority sits in the top bits

	// ======================================================================
	// line map
	localparam int LINE_POWER        = 0;
	localparam int LINE_SYS_CONTROL  = 1;
	localparam int LINE_WATCHDOG     = 2;
	localparam int LINE_RTC          = 3;
	localparam int LINE_EXT_IRQ      = 4;
	localparam int LINE_NVM          = 5;
	localparam int LINE_EVENT_ROUTER = 6;
	localparam int LINE_SERIAL_BASE  = 7;
	localparam int LINE_TIMER_BASE   = 13;
	localparam int LINE_ADC          = 21;
	localparam int LINE_ANALOG_CMP   = 22;

	// ======================================================================
	// reset values
	localparam logic [SRC_W-1:0]      FLAG_RST    = 8'h00;
	localparam logic [SRC_W-1:0]      ENABLE_RST  = 8'h00;
	localparam logic [PRIO_REG_W-1:0] PRIO_RST    = 32'h00000000;

	// ======================================================================
	// peripheral-side write kinds
	typedef enum logic [1:0] {
		PIA_WR_FLAG_CLR = 2'h0,
		PIA_WR_EN_SET   = 2'h1,
		PIA_WR_EN_CLR   = 2'h3
	} pia_wr_kind_e;

endpackage

// ==== logic/pia_src_unit.sv ====
`timescale 1ns/100ps
// ==========================================================================
// one peripheral: sticky flags, individual enables, one gated request
// ==========================================================================
module pia_src_unit #(
	parameter int SRC_W = pia_pkg::SRC_W
) (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic [SRC_W-1:0] events,
	input  wire logic             flag_clear_we,
	input  wire logic             enable_set_we,
	input  wire logic             enable_clear_we,
	input  wire logic [SRC_W-1:0] wr_data,
	output logic      [SRC_W-1:0] pending_event_flags,
	output logic      [SRC_W-1:0] enables,
	output logic                  irq
);

	logic [SRC_W-1:0] next_flags;
	logic [SRC_W-1:0] next_enables;
	logic [SRC_W-1:0] clr_mask;

	// ======================================================================
	// next values; a new event beats a clear in the same cycle
	assign clr_mask     = flag_clear_we ? wr_data : '0;
	assign next_flags   = (pending_event_flags & ~clr_mask) | events;
	assign next_enables = enable_set_we   ? (enables | wr_data)
	                    : enable_clear_we ? (enables & ~wr_data)
	                    : enables;

	// ======================================================================
	// request follows flags and enables exactly, from the next values
	always_ff @(posedge clk) begin
		if (rst) begin
			pending_event_flags <= pia_pkg::FLAG_RST;
			enables             <= pia_pkg::ENABLE_RST;
			irq                 <= 1'b0;
		end else begin
			pending_event_flags <= next_flags;
			enables             <= next_enables;
			irq                 <= |(next_flags & next_enables);
		end
	end

	// ======================================================================
	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	flag_set_a: assert property ((|events) |=>
		((pending_event_flags & $past(events)) == $past(events)))
		else $error("event did not set its flag");

	flag_hold_a: assert property ((!flag_clear_we && (|pending_event_flags)) |=>
		((pending_event_flags & $past(pending_event_flags)) == $past(pending_event_flags)))
		else $error("flag dropped without a clear");

	flag_clear_a: assert property ((flag_clear_we && events == '0) |=>
		((pending_event_flags & $past(wr_data)) == '0))
		else $error("flag clear did not take");

	en_set_a: assert property (enable_set_we |=>
		(enables == ($past(enables) | $past(wr_data))))
		else $error("enable set wrong");

	en_clear_a: assert property ((enable_clear_we && !enable_set_we) |=>
		(enables == ($past(enables) & ~$past(wr_data))))
		else $error("enable clear wrong");

	irq_gate_a: assert property (irq == |(pending_event_flags & enables))
		else $error("request not equal to gated flags");

endmodule

// ==== logic/pia_aggregator.sv ====
`timescale 1ns/100ps

// ==========================================================================
// peripheral interrupt aggregation and core-side line controller
// ==========================================================================
module pia_aggregator #(
	parameter int NUM_LINES = pia_pkg::NUM_LINES,
	parameter int SRC_W     = pia_pkg::SRC_W,
	parameter int PRIO_W    = pia_pkg::PRIO_W
) (
	input  wire logic                                         clk,
	input  wire logic                                         rst,
	// peripheral interrupt conditions, one-cycle or level
	input  wire logic [pia_pkg::NUM_SYS*SRC_W-1:0]            sys_unit_events,
	input  wire logic [pia_pkg::NUM_SERIAL*SRC_W-1:0]         serial_unit_events,
	input  wire logic [pia_pkg::NUM_TIMER*SRC_W-1:0]          timer_unit_events,
	input  wire logic [SRC_W-1:0]                             adc_unit_events,
	input  wire logic [SRC_W-1:0]                             analog_comparator_unit_events,
	input  wire logic                                         ext_nmi_event,
	// peripheral flag and enable writes, the unit addressed by its line
	input  wire logic                                         unit_wr_valid,
	input  wire logic [pia_pkg::LINE_W-1:0]                   unit_wr_line,
	input  wire pia_pkg::pia_wr_kind_e                        unit_wr_kind,
	input  wire logic [SRC_W-1:0]                             unit_wr_data,
	// core line controller writes, one-cycle bit masks
	input  wire logic [NUM_LINES-1:0]                         line_pending_set_reg,
	input  wire logic [NUM_LINES-1:0]                         line_pending_clear_reg,
	input  wire logic [NUM_LINES-1:0]                         line_enable_set_reg,
	input  wire logic [NUM_LINES-1:0]                         line_enable_clear_reg,
	input  wire logic                                         prio_wr_valid,
	input  wire logic [pia_pkg::PRIO_IDX_W-1:0]               prio_wr_index,
	input  wire logic [pia_pkg::PRIO_REG_W-1:0]               prio_wr_data,
	// results
	output logic      [NUM_LINES-1:0]                         periph_irq,
	output logic      [NUM_LINES-1:0]                         pending_set_bits,
	output logic      [NUM_LINES-1:0]                         line_enable_bits,
	output logic      [SRC_W-1:0]                             unit_flag_rd,
	output logic                                              core_irq_valid,
	output logic      [pia_pkg::LINE_W-1:0]                   core_irq_line,
	output logic      [PRIO_W-1:0]                            core_irq_prio,
	output logic                                              nmi_req
);

	logic [NUM_LINES-1:0][SRC_W-1:0]  line_events;
	logic [NUM_LINES-1:0][SRC_W-1:0]  line_flags;
	logic [NUM_LINES-1:0]             src_irq;
	logic [NUM_LINES-1:0]             flag_clear_we;
	logic [NUM_LINES-1:0]             enable_set_we;
	logic [NUM_LINES-1:0]             enable_clear_we;
	logic [NUM_LINES-1:0][PRIO_W-1:0] line_prio;
	logic [NUM_LINES-1:0]             next_pending;
	logic [NUM_LINES-1:0]             next_enable;
	logic [NUM_LINES-1:0]             candidates;
	logic                             next_valid;
	logic [pia_pkg::LINE_W-1:0]       next_line;
	logic [PRIO_W-1:0]                next_prio;

	logic [pia_pkg::NUM_PRIO_REGS-1:0][pia_pkg::PRIO_REG_W-1:0] line_priority_regs;

	// ======================================================================
	// fixed routing of peripherals onto lines
	generate
		for (genvar s = 0; s < pia_pkg::NUM_SYS; s++) begin : g_sys
			// system units arrive in line order: power, control, watchdog,
			// counter, external unit, memory controller, event router
			assign line_events[pia_pkg::LINE_POWER + s] =
				sys_unit_events[s*SRC_W +: SRC_W];
		end
		for (genvar s = 0; s < pia_pkg::NUM_SERIAL; s++) begin : g_serial
			assign line_events[pia_pkg::LINE_SERIAL_BASE + s] =
				serial_unit_events[s*SRC_W +: SRC_W];
		end
		for (genvar s = 0; s < pia_pkg::NUM_TIMER; s++) begin : g_timer
			assign line_events[pia_pkg::LINE_TIMER_BASE + s] =
				timer_unit_events[s*SRC_W +: SRC_W];
		end
	endgenerate
	assign line_events[pia_pkg::LINE_ADC]        = adc_unit_events;
	assign line_events[pia_pkg::LINE_ANALOG_CMP] = analog_comparator_unit_events;

	// ======================================================================
	// per-line peripheral units and their write decode
	generate
		for (genvar l = 0; l < NUM_LINES; l++) begin : g_unit
			logic hit;
			assign hit                = unit_wr_valid
			                          && unit_wr_line == pia_pkg::LINE_W'(l);
			assign flag_clear_we[l]   = hit && unit_wr_kind == pia_pkg::PIA_WR_FLAG_CLR;
			assign enable_set_we[l]   = hit && unit_wr_kind == pia_pkg::PIA_WR_EN_SET;
			assign enable_clear_we[l] = hit && unit_wr_kind == pia_pkg::PIA_WR_EN_CLR;

			// the unit itself ORs its gated flags into one request
			pia_src_unit #(
				.SRC_W (SRC_W)
			) u_src (
				.clk                 (clk),
				.rst                 (rst),
				.events              (line_events[l]),
				.flag_clear_we       (flag_clear_we[l]),
				.enable_set_we       (enable_set_we[l]),
				.enable_clear_we     (enable_clear_we[l]),
				.wr_data             (unit_wr_data),
				.pending_event_flags (line_flags[l]),
				.enables             (),
				.irq                 (src_irq[l])
			);

			// priority field of this line sits in the top bits of its byte
			assign line_prio[l] = line_priority_regs[l / pia_pkg::LINES_PER_PRIO]
				[(l % pia_pkg::LINES_PER_PRIO) * pia_pkg::PRIO_FIELD_BITS
				 + pia_pkg::PRIO_FIELD_TOP -: PRIO_W];
		end
	endgenerate

	// ======================================================================
	// pending and line enable next values
	// hardware requests and software sets beat a pending clear; for the line
	// enable a simultaneous set and clear leaves the line disabled
	assign next_pending = (pending_set_bits & ~line_pending_clear_reg)
	                    | line_pending_set_reg | src_irq;
	assign next_enable  = (line_enable_bits | line_enable_set_reg)
	                    & ~line_enable_clear_reg;
	assign candidates   = pending_set_bits & line_enable_bits;

	// ======================================================================
	// arbitration: lowest priority value wins, lowest line number on a tie
	always_comb begin
		next_valid = 1'b0;
		next_line  = '0;
		next_prio  = '0;
		for (int l = NUM_LINES - 1; l >= 0; l--) begin
			if (candidates[l] && (!next_valid || line_prio[l] <= next_prio)) begin
				next_valid = 1'b1;
				next_line  = pia_pkg::LINE_W'(l);
				next_prio  = line_prio[l];
			end
		end
	end

	// ======================================================================
	// line controller state
	always_ff @(posedge clk) begin
		if (rst) begin
			pending_set_bits <= '0;
			line_enable_bits <= '0;
		end else begin
			pending_set_bits <= next_pending;
			line_enable_bits <= next_enable;
		end
	end

	// priority bank; only the top field bits are ever looked at
	always_ff @(posedge clk) begin
		if (rst) begin
			line_priority_regs <= {pia_pkg::NUM_PRIO_REGS{pia_pkg::PRIO_RST}};
		end else if (prio_wr_valid) begin
			line_priority_regs[prio_wr_index] <= prio_wr_data;
		end
	end

	// ======================================================================
	// registered outputs; the active choice lags pending by one cycle
	always_ff @(posedge clk) begin
		if (rst) begin
			periph_irq     <= '0;
			unit_flag_rd   <= '0;
			core_irq_valid <= 1'b0;
			core_irq_line  <= '0;
			core_irq_prio  <= '0;
			nmi_req        <= 1'b0;
		end else begin
			periph_irq     <= src_irq;
			unit_flag_rd   <= (unit_wr_line < pia_pkg::LINE_W'(NUM_LINES))
			                ? line_flags[unit_wr_line] : '0;
			core_irq_valid <= next_valid;
			core_irq_line  <= next_line;
			core_irq_prio  <= next_prio;
			nmi_req        <= ext_nmi_event;
		end
	end

	// ======================================================================
	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	// helper: priority of the line now presented
	logic [PRIO_W-1:0] shown_prio;
	assign shown_prio = line_prio[core_irq_line];

	sequence watchdog_event_s;
		|sys_unit_events[pia_pkg::LINE_WATCHDOG*SRC_W +: SRC_W];
	endsequence
	// the flag is what an event must reach, whatever the enables are
	sequence watchdog_flag_s;
		##1 (line_flags[pia_pkg::LINE_WATCHDOG] != '0);
	endsequence

	wdt_line_map_a: assert property (watchdog_event_s |-> watchdog_flag_s)
		else $error("watchdog event missed line 2");

	serial_line_map_a: assert property ((|serial_unit_events[5*SRC_W +: SRC_W]) |->
		##1 line_flags[12] != '0)
		else $error("serial unit 5 not on line 12");

	timer_line_map_a: assert property ((|timer_unit_events[SRC_W-1:0]) |->
		##1 line_flags[13] != '0)
		else $error("timer unit 0 not on line 13");

	analog_line_map_a: assert property ((|analog_comparator_unit_events) |->
		##1 line_flags[22] != '0)
		else $error("comparator not on line 22");

	or_combine_a: assert property (periph_irq == $past(src_irq))
		else $error("line request not the unit OR");

	pend_set_a: assert property ((|src_irq) |=>
		((pending_set_bits & $past(src_irq)) == $past(src_irq)))
		else $error("request did not set pending");

	pend_clear_a: assert property ((line_pending_clear_reg != '0 && src_irq == '0 &&
		line_pending_set_reg == '0) |=>
		((pending_set_bits & $past(line_pending_clear_reg)) == '0))
		else $error("pending clear did not take");

	active_enabled_a: assert property (core_irq_valid |->
		|($past(pending_set_bits & line_enable_bits) & (NUM_LINES'(1) << core_irq_line)))
		else $error("line activated while disabled or idle");

	no_active_a: assert property (($past(pending_set_bits & line_enable_bits) == '0) |->
		!core_irq_valid)
		else $error("activation with no candidate");

	prio_field_a: assert property ((core_irq_valid && !$past(prio_wr_valid)) |->
		core_irq_prio == shown_prio)
		else $error("presented priority differs from field");

	nmi_route_a: assert property (nmi_req == $past(ext_nmi_event))
		else $error("non-maskable source not routed");

endmodule

// ==== verification/pia_core_model.sv ====
`timescale 1ns/100ps
// ==========================================================================
// core line controller writes as software would issue them
// ==========================================================================
module pia_core_model (
	input  wire logic                           clk,
	input  wire logic                           core_irq_valid,
	input  wire logic [pia_pkg::LINE_W-1:0]     core_irq_line,
	output logic      [pia_pkg::NUM_LINES-1:0]  line_pending_set_reg,
	output logic      [pia_pkg::NUM_LINES-1:0]  line_pending_clear_reg,
	output logic      [pia_pkg::NUM_LINES-1:0]  line_enable_set_reg,
	output logic      [pia_pkg::NUM_LINES-1:0]  line_enable_clear_reg,
	output logic                                prio_wr_valid,
	output logic      [pia_pkg::PRIO_IDX_W-1:0] prio_wr_index,
	output logic      [pia_pkg::PRIO_REG_W-1:0] prio_wr_data
);
	logic [pia_pkg::LINE_W-1:0] taken_line;

	// ======================================================================
	// masks idle low, so a write is a one-cycle strobe and never a level
	initial begin
		line_pending_set_reg = '0;
		line_pending_clear_reg = '0;
		line_enable_set_reg = '0;
		line_enable_clear_reg = '0;
		prio_wr_valid = 1'b0;
		prio_wr_index = '0;
		prio_wr_data = '0;
		taken_line = '0;
	end

	// the core only takes a line software enabled; remember the last one
	always @(posedge clk)
		if (core_irq_valid === 1'b1) taken_line <= core_irq_line;

	// one mask write: 0 pend set, 1 pend clear, 2 enable set, 3 enable clear
	task automatic pulse(input int which, input logic [pia_pkg::NUM_LINES-1:0] mask);
		@(negedge clk);
		case (which)
			0: line_pending_set_reg = mask;
			1: line_pending_clear_reg = mask;
			2: line_enable_set_reg = mask;
			default: line_enable_clear_reg = mask;
		endcase
		@(negedge clk);
		line_pending_set_reg = '0;
		line_pending_clear_reg = '0;
		line_enable_set_reg = '0;
		line_enable_clear_reg = '0;
	endtask

	// one write of the priority bank
	task automatic prio(input int idx, input logic [31:0] data);
		@(negedge clk);
		prio_wr_valid = 1'b1;
		prio_wr_index = 3'(idx);
		prio_wr_data = data;
		@(negedge clk);
		prio_wr_valid = 1'b0;
	endtask
endmodule

// ==== verification/testbench.sv ====
`timescale 1ns/100ps
// ==========================================================================
// self-checking bench of the interrupt aggregation block
// ==========================================================================
module testbench;
	logic        clk;
	logic        rst;
	logic [55:0] sys_ev;
	logic [47:0] ser_ev;
	logic [63:0] tmr_ev;
	logic [7:0]  adc_ev;
	logic [7:0]  cmp_ev;
	logic        nmi_ev;
	logic        wr_valid;
	logic [4:0]  wr_line;
	logic [1:0]  wr_kind;
	logic [7:0]  wr_data;
	logic [22:0] pset, pclr, eset, eclr;
	logic        pr_valid;
	logic [2:0]  pr_index;
	logic [31:0] pr_data;
	logic [22:0] periph_irq, pending_set_bits, line_enable_bits;
	logic [7:0]  unit_flag_rd;
	logic        core_irq_valid, nmi_req;
	logic [4:0]  core_irq_line;
	logic [1:0]  core_irq_prio;
	int          err_count;
	int          samples_checked;

	// ======================================================================
	// design and core stand-in
	pia_aggregator i_dut (.clk(clk), .rst(rst), .sys_unit_events(sys_ev),
		.serial_unit_events(ser_ev), .timer_unit_events(tmr_ev), .adc_unit_events(adc_ev),
		.analog_comparator_unit_events(cmp_ev), .ext_nmi_event(nmi_ev),
		.unit_wr_valid(wr_valid), .unit_wr_line(wr_line),
		.unit_wr_kind(pia_pkg::pia_wr_kind_e'(wr_kind)), .unit_wr_data(wr_data),
		.line_pending_set_reg(pset), .line_pending_clear_reg(pclr),
		.line_enable_set_reg(eset), .line_enable_clear_reg(eclr),
		.prio_wr_valid(pr_valid), .prio_wr_index(pr_index), .prio_wr_data(pr_data),
		.periph_irq(periph_irq), .pending_set_bits(pending_set_bits),
		.line_enable_bits(line_enable_bits), .unit_flag_rd(unit_flag_rd),
		.core_irq_valid(core_irq_valid), .core_irq_line(core_irq_line),
		.core_irq_prio(core_irq_prio), .nmi_req(nmi_req));
	pia_core_model i_core (.clk(clk), .core_irq_valid(core_irq_valid),
		.core_irq_line(core_irq_line), .line_pending_set_reg(pset),
		.line_pending_clear_reg(pclr), .line_enable_set_reg(eset),
		.line_enable_clear_reg(eclr), .prio_wr_valid(pr_valid),
		.prio_wr_index(pr_index), .prio_wr_data(pr_data));

	// 250 MHz clock
	always #2 clk = ~clk;

	// ======================================================================
	// helpers; every driver changes inputs at the falling edge only
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic summarize();
		$display("comparisons %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// a unit write; the line is left selected so the flag readback follows it
	task automatic uw(input int l, input logic [1:0] k, input logic [7:0] d);
		@(negedge clk);
		wr_valid = 1'b1;
		wr_line = 5'(l);
		wr_kind = k;
		wr_data = d;
		@(negedge clk);
		wr_valid = 1'b0;
	endtask

	// one-cycle condition on bit b of the unit behind line l
	task automatic fire(input int l, input int b);
		@(negedge clk);
		if (l < pia_pkg::LINE_SERIAL_BASE) sys_ev[8*l+b] = 1'b1;
		else if (l < pia_pkg::LINE_TIMER_BASE) ser_ev[8*(l-7)+b] = 1'b1;
		else if (l < pia_pkg::LINE_ADC) tmr_ev[8*(l-13)+b] = 1'b1;
		else if (l == pia_pkg::LINE_ADC) adc_ev[b] = 1'b1;
		else cmp_ev[b] = 1'b1;
		@(negedge clk);
		{sys_ev, ser_ev, tmr_ev, adc_ev, cmp_ev} = '0;
	endtask

	// bounded wait for a line request; a hang ends the run
	task automatic wait_irq(input int l);
		for (int i = 0; i < 10; i++) begin
			if (periph_irq[l] === 1'b1) return;
			@(negedge clk);
		end
		err_count++;
		$display("[ERR] wait line %0d expected 1 seen %b", l, periph_irq[l]);
		summarize();
	endtask

	// ======================================================================
	// scenarios
	task automatic t_map();
		int b;
		for (int l = 0; l < pia_pkg::NUM_LINES; l++) begin
			b = l % 8;
			uw(l, 2'h1, 8'(1 << b));
			fire(l, b);
			wait_irq(l);
			cyc(2);
			chk("line irq", 32'(1) << l, 32'(periph_irq));
			chk("line pend", 32'(1) << l, 32'(pending_set_bits));
			uw(l, 2'h0, 8'(1 << b));
			uw(l, 2'h3, 8'(1 << b));
			cyc(3);
			i_core.pulse(1, '1);
			cyc(3);
			chk("pend clear", 32'h0, 32'(pending_set_bits | periph_irq));
		end
		$display("line map done");
	endtask

	task automatic t_enables();
		fire(13, 0);
		fire(13, 2);
		uw(13, 2'h0, 8'h00);
		cyc(4);
		chk("no enable", 32'h0, 32'(periph_irq));
		chk("flags", 32'h05, 32'(unit_flag_rd));
		uw(13, 2'h1, 8'h04);
		uw(13, 2'h1, 8'h00);
		uw(13, 2'h3, 8'h01);
		cyc(4);
		chk("one enabled", 32'h2000, 32'(periph_irq));
		uw(13, 2'h0, 8'h04);
		cyc(4);
		chk("flag cleared", 32'h01, 32'(unit_flag_rd));
		chk("drop", 32'h0, 32'(periph_irq));
		uw(13, 2'h2, 8'hff);
		uw(23, 2'h1, 8'hff);
		cyc(4);
		chk("ignored", 32'h0, 32'(periph_irq));
		chk("no unit", 32'h0, 32'(unit_flag_rd));
		uw(13, 2'h1, 8'h01);
		cyc(4);
		chk("other bit", 32'h2000, 32'(periph_irq));
		uw(13, 2'h0, 8'hff);
		uw(13, 2'h3, 8'hff);
		cyc(3);
		i_core.pulse(1, '1);
		$display("enables done");
	endtask

	task automatic t_core();
		i_core.pulse(0, 23'h000208);
		cyc(4);
		chk("pend set", 32'h208, 32'(pending_set_bits));
		chk("not enabled", 32'h0, 32'(core_irq_valid));
		i_core.pulse(2, 23'h000208);
		cyc(4);
		chk("enables", 32'h208, 32'(line_enable_bits));
		chk("tie low", 32'h23, 32'({core_irq_valid, core_irq_line}));
		i_core.prio(0, 32'hc0000000);
		i_core.prio(2, 32'h00004000);
		cyc(4);
		chk("prio win", 32'ha5, 32'({core_irq_valid, core_irq_line, core_irq_prio}));
		chk("taken", 32'h9, 32'(i_core.taken_line));
		i_core.pulse(3, 23'h000200);
		cyc(4);
		chk("after off", 32'h8f, 32'({core_irq_valid, core_irq_line, core_irq_prio}));
		i_core.pulse(1, 23'h000008);
		cyc(4);
		chk("pend left", 32'h200, 32'(pending_set_bits));
		chk("idle", 32'h0, 32'(core_irq_valid));
		$display("core side done");
	endtask

	task automatic t_nmi();
		@(negedge clk);
		nmi_ev = 1'b1;
		@(negedge clk);
		nmi_ev = 1'b0;
		chk("nmi", 32'h1, 32'(nmi_req));
		cyc(3);
		chk("nmi off", 32'h0, 32'(nmi_req));
		chk("no line", 32'h0, 32'(periph_irq[pia_pkg::LINE_EXT_IRQ]));
		chk("no pend", 32'h0, 32'(pending_set_bits[pia_pkg::LINE_EXT_IRQ]));
		$display("non-maskable done");
	endtask

	// ======================================================================
	// main sequence: hold reset three cycles, then every scenario
	initial begin
		clk = 1'b0;
		rst = 1'b1;
		{sys_ev, ser_ev, tmr_ev, adc_ev, cmp_ev} = '0;
		{nmi_ev, wr_valid, wr_line, wr_kind, wr_data} = '0;
		err_count = 0;
		samples_checked = 0;
		repeat (3) @(negedge clk);
		rst = 1'b0;
		chk("reset", 32'h0, 32'(periph_irq | pending_set_bits | line_enable_bits));
		t_map();
		t_enables();
		t_core();
		t_nmi();
		summarize();
	end
endmodule
